// file: core/cpa_consts.svh
// Constants of the counter array compare and watchdog block
`ifndef CPA_CONSTS_SVH
`define CPA_CONSTS_SVH

// ************************************************************
// Timebase select codes
// ************************************************************
`define CPA_TB_DIV12 3'h0
`define CPA_TB_DIV4 3'h1
`define CPA_TB_T0OVF 3'h2
`define CPA_TB_EXTIN 3'h3
`define CPA_TB_SYSCLK 3'h4
`define CPA_TB_OSC8 3'h5

// ************************************************************
// Prescaler counts
// ************************************************************
`define CPA_PRE_LAST 4'hb
`define CPA_DIV4_LAST 2'h3
`define CPA_OSC_LAST 3'h7

// ************************************************************
// Field positions in write data
// ************************************************************
`define CPA_CTL_RUN 6
`define CPA_AMD_IDLE 7
`define CPA_AMD_WDE 6
`define CPA_AMD_LOCK 5
`define CPA_AMD_TB_LSB 1
`define CPA_AMD_TB_MSB 3

// ************************************************************
// Reset values and forced values
// ************************************************************
`define CPA_WDE_RST 1'b1
`define CPA_TB_RST 3'h0
`define CPA_BYTE_RST 8'h00
`define CPA_MODE_RST 8'h00
`define CPA_MODE_SWTIMER 8'h48

`endif

// file: core/cpa_core.sv
// Compare, pwm and watchdog logic of the five-module counter array
`timescale 1ns/1ps
`default_nettype none
`include "cpa_consts.svh"

// Behaviour
// - Timer mode: counter equals compare sets flag
// - Hardware never clears a match flag
// - Comparator and match set, others clear: timer
// - Low write clears, high write sets comparator
// - High-speed mode inverts pin on each match
// - Frequency mode: low match toggles, adds high
// - High byte zero means 256-clock half-period
// - Pwm8: set on low match, clear on wrap
// - Pwm8: wrap reloads low from high byte
// - Pwm8 selected when wide bit clear
// - Pwm with comparator off drives low
// - Pwm16: set on full match, clear on overflow
// - Watchdog uses module four high and offset
// - Watchdog forces counter, freezes selects, mode
// - Run bit cannot stop counter under watchdog
// - Watchdog update loads counter high plus offset
// - Low wrap with high match resets device
// - Writing module four flag forces reset
// - Enable or lock enables; lock holds
// - Reset: watchdog on, divide-by-12, bytes zero
// - Three-bit timebase select chooses source
module cpa_core #(
   parameter int NUM_MOD = 5,
   parameter int WD_MOD = 4
) (
   // Clock, reset and enable
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   // System status and count sources
   input wire logic cpu_idle,
   input wire logic timer0_ovf,
   input wire logic ext_count_pin,
   input wire logic ext_osc_pin,
   // Software write port
   input wire cpa_pkg::cpa_wr_t wr,
   // Module outputs and flags
   output logic [NUM_MOD-1:0] module_io_pin,
   output logic [NUM_MOD-1:0] module_match_flag,
   output logic match_irq,
   // Counter and watchdog status
   output logic [15:0] count_value,
   output logic counter_run_bit,
   output logic watchdog_active,
   output logic watchdog_reset
);

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [15:0] cnt_q;                  // Running counter
   logic [15:0] cnt_nxt;                // Counter after this tick
   logic run_q;                         // Software run bit
   logic idle_q;                        // Idle suspend bit
   logic wde_q;                         // Watchdog enable bit
   logic lock_q;                        // Watchdog lock bit
   logic [2:0] tb_q;                    // Timebase select
   logic wd_en;                         // Watchdog in force
   logic tb_tick;                       // Raw timebase tick
   logic tick;                          // Tick gated by run control
   logic low_ovf;                       // Low byte wraps this tick
   logic full_ovf;                      // Whole counter wraps this tick
   cpa_pkg::cpa_mode_t mode_q [NUM_MOD];  // Stored module modes
   cpa_pkg::cpa_mode_t eff [NUM_MOD];     // Modes as they act
   logic [7:0] cpl_q [NUM_MOD];         // Compare low bytes
   logic [7:0] cph_q [NUM_MOD];         // Compare high bytes
   logic [NUM_MOD-1:0] m16_v;           // Full 16-bit matches
   logic [NUM_MOD-1:0] m8_v;            // Low byte matches
   logic [NUM_MOD-1:0] hw_set;          // Flag set events
   logic [NUM_MOD-1:0] ien;             // Interrupt enables
   logic [NUM_MOD-1:0] flag_q;
   logic [NUM_MOD-1:0] pin_q;
   logic irq_q;
   logic wd_rst_q;
   logic wd_act_q;
   logic [7:0] wd_upd;                  // Reload value for watchdog
   logic wd_hit;
   logic wd_force;

   // ************************************************************
   // Decode helpers
   // ************************************************************
   // True when the write hits the given target
   function automatic logic wr_hit(input cpa_pkg::cpa_wr_t w,
                                   input cpa_pkg::cpa_wr_sel_t s);
      return w.en && (w.sel == s);
   endfunction : wr_hit

   // Pwm family: pwm bit set and toggle clear
   function automatic logic is_pwm(input cpa_pkg::cpa_mode_t m);
      return m.pwm && !m.toggle;
   endfunction : is_pwm

   // Frequency output: comparator, toggle and pwm set
   function automatic logic is_freq(input cpa_pkg::cpa_mode_t m);
      return m.comp_en && m.toggle && m.pwm;
   endfunction : is_freq

   // ************************************************************
   // Timebase
   // ************************************************************
   cpa_timebase u_tb (
      .core_clk(core_clk),
      .reset(reset),
      .clk_en(clk_en),
      .sel(tb_q),
      .timer0_ovf(timer0_ovf),
      .ext_count_pin(ext_count_pin),
      .ext_osc_pin(ext_osc_pin),
      .tick(tb_tick)
   );

   assign wd_en = wde_q || lock_q;
   // Watchdog keeps the counter running whatever the run bit says
   assign tick = tb_tick && (run_q || wd_en) && !(cpu_idle && idle_q);
   assign cnt_nxt = cnt_q + 16'h0001;
   assign low_ovf = tick && (cnt_q[7:0] == 8'hff);
   assign full_ovf = tick && (cnt_q == 16'hffff);

   // ************************************************************
   // Counter
   // ************************************************************
   // Counter byte writes are dropped while the watchdog is on
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cnt_q <= {`CPA_BYTE_RST, `CPA_BYTE_RST};
      end else if (clk_en) begin
         if (!wd_en && wr_hit(wr, cpa_pkg::CPA_WR_CNT_LO)) begin
            cnt_q[7:0] <= wr.data;
         end else if (!wd_en && wr_hit(wr, cpa_pkg::CPA_WR_CNT_HI)) begin
            cnt_q[15:8] <= wr.data;
         end else if (tick) begin
            cnt_q <= cnt_nxt;
         end
      end
   end

   // ************************************************************
   // Array mode and run control
   // ************************************************************
   // Timebase and idle bits freeze under the watchdog
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wde_q <= `CPA_WDE_RST;
         lock_q <= 1'b0;
         idle_q <= 1'b0;
         tb_q <= `CPA_TB_RST;
      end else if (clk_en && wr_hit(wr, cpa_pkg::CPA_WR_AMODE)) begin
         wde_q <= wr.data[`CPA_AMD_WDE];
         lock_q <= lock_q || wr.data[`CPA_AMD_LOCK];
         if (!wd_en) begin
            idle_q <= wr.data[`CPA_AMD_IDLE];
            tb_q <= wr.data[`CPA_AMD_TB_MSB:`CPA_AMD_TB_LSB];
         end
      end
   end

   // Run bit reads back only what software wrote
   always_ff @(posedge core_clk) begin
      if (reset) begin
         run_q <= 1'b0;
      end else if (clk_en && wr_hit(wr, cpa_pkg::CPA_WR_CTRL)) begin
         run_q <= wr.data[`CPA_CTL_RUN];
      end
   end

   assign wd_upd = cnt_q[15:8] + cpl_q[WD_MOD];

   // ************************************************************
   // Capture/compare modules
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < NUM_MOD; gi++) begin : g_mod
         logic sel_me;      // Write addresses this module
         logic locked;      // Module held by the watchdog
         logic pwm8_reload; // Low wraps in 8-bit pwm
         logic [7:0] ref8;  // Low byte compared this tick

         assign sel_me = (wr.idx == 3'(gi));
         assign locked = (gi == WD_MOD) && wd_en;
         // Module four acts as a plain timer under the watchdog
         assign eff[gi] = locked ? cpa_pkg::cpa_mode_t'(`CPA_MODE_SWTIMER) : mode_q[gi];
         assign pwm8_reload = is_pwm(eff[gi]) && !eff[gi].wide && low_ovf;
         // On a wrap the reloaded value is the one that counts
         assign ref8 = pwm8_reload ? cph_q[gi] : cpl_q[gi];
         assign m16_v[gi] = tick && (cnt_nxt == {cph_q[gi], cpl_q[gi]});
         assign m8_v[gi] = tick && (cnt_nxt[7:0] == ref8);
         assign ien[gi] = eff[gi].irq_en;
         // Frequency mode never raises the flag
         assign hw_set[gi] = eff[gi].comp_en && eff[gi].match_en && !is_freq(eff[gi])
                             && ((is_pwm(eff[gi]) && !eff[gi].wide) ? m8_v[gi] : m16_v[gi]);

         // Mode register with comparator side effects of byte writes
         always_ff @(posedge core_clk) begin
            if (reset) begin
               mode_q[gi] <= cpa_pkg::cpa_mode_t'(`CPA_MODE_RST);
            end else if (clk_en && sel_me) begin
               if (wr_hit(wr, cpa_pkg::CPA_WR_CMP_LO)) begin
                  mode_q[gi].comp_en <= 1'b0;
               end else if (wr_hit(wr, cpa_pkg::CPA_WR_CMP_HI)) begin
                  mode_q[gi].comp_en <= 1'b1;
               end else if (wr_hit(wr, cpa_pkg::CPA_WR_MMODE) && !locked) begin
                  mode_q[gi] <= cpa_pkg::cpa_mode_t'(wr.data);
               end
            end
         end

         // Compare low byte: software load, frequency step, pwm reload
         always_ff @(posedge core_clk) begin
            if (reset) begin
               cpl_q[gi] <= `CPA_BYTE_RST;
            end else if (clk_en) begin
               if (sel_me && wr_hit(wr, cpa_pkg::CPA_WR_CMP_LO)) begin
                  cpl_q[gi] <= wr.data;
               end else if (is_freq(eff[gi]) && m8_v[gi]) begin
                  // A zero step wraps through all 256 counts
                  cpl_q[gi] <= cpl_q[gi] + cph_q[gi];
               end else if (pwm8_reload) begin
                  cpl_q[gi] <= cph_q[gi];
               end
            end
         end

         // Compare high byte; watchdog writes load counter plus offset
         always_ff @(posedge core_clk) begin
            if (reset) begin
               cph_q[gi] <= `CPA_BYTE_RST;
            end else if (clk_en && sel_me && wr_hit(wr, cpa_pkg::CPA_WR_CMP_HI)) begin
               cph_q[gi] <= locked ? wd_upd : wr.data;
            end
         end

         // Output pin; in pwm a match wins over the wrap for 100 percent
         always_ff @(posedge core_clk) begin
            if (reset) begin
               pin_q[gi] <= 1'b0;
            end else if (clk_en) begin
               if (is_pwm(eff[gi])) begin
                  if (!eff[gi].comp_en) begin
                     pin_q[gi] <= 1'b0;
                  end else if (eff[gi].wide ? m16_v[gi] : m8_v[gi]) begin
                     pin_q[gi] <= 1'b1;
                  end else if (eff[gi].wide ? full_ovf : low_ovf) begin
                     pin_q[gi] <= 1'b0;
                  end
               end else if (is_freq(eff[gi])) begin
                  if (m8_v[gi]) begin
                     pin_q[gi] <= ~pin_q[gi];
                  end
               end else if (eff[gi].comp_en && eff[gi].match_en && eff[gi].toggle
                            && m16_v[gi]) begin
                  pin_q[gi] <= ~pin_q[gi];
               end
            end
         end
      end
   endgenerate

   // ************************************************************
   // Match flags and interrupt
   // ************************************************************
   // A hardware set wins over a software clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         flag_q <= '0;
      end else if (clk_en) begin
         if (wr_hit(wr, cpa_pkg::CPA_WR_CTRL)) begin
            flag_q <= wr.data[NUM_MOD-1:0] | hw_set;
         end else begin
            flag_q <= flag_q | hw_set;
         end
      end
   end

   // Interrupt follows the flags one cycle later
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else if (clk_en) begin
         irq_q <= |(flag_q & ien);
      end
   end

   // ************************************************************
   // Watchdog reset
   // ************************************************************
   assign wd_hit = wd_en && low_ovf && (cph_q[WD_MOD] == cnt_q[15:8]);
   assign wd_force = wd_en && wr_hit(wr, cpa_pkg::CPA_WR_CTRL) && wr.data[WD_MOD];

   // Single-cycle request to the reset controller
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wd_rst_q <= 1'b0;
         wd_act_q <= 1'b1;
      end else if (clk_en) begin
         wd_rst_q <= wd_hit || wd_force;
         wd_act_q <= wd_en;
      end
   end

   assign module_io_pin = pin_q;
   assign module_match_flag = flag_q;
   assign match_irq = irq_q;
   assign count_value = cnt_q;
   assign counter_run_bit = run_q;
   assign watchdog_active = wd_act_q;
   assign watchdog_reset = wd_rst_q;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   chk_flag_no_clear: assert property (
      (flag_q[0] && !wr_hit(wr, cpa_pkg::CPA_WR_CTRL)) |=> flag_q[0])
      else $error("match flag dropped without software");
   chk_timer_flag: assert property (
      (clk_en && eff[0].comp_en && eff[0].match_en && !eff[0].toggle && !eff[0].pwm
       && m16_v[0]) |=> flag_q[0])
      else $error("timer match did not set flag");
   chk_low_clears_comp: assert property (
      (clk_en && wr.idx == 3'h0 && wr_hit(wr, cpa_pkg::CPA_WR_CMP_LO)) |=> !mode_q[0].comp_en)
      else $error("low byte write kept comparator");
   chk_high_sets_comp: assert property (
      (clk_en && wr.idx == 3'h0 && wr_hit(wr, cpa_pkg::CPA_WR_CMP_HI)) |=> mode_q[0].comp_en)
      else $error("high byte write left comparator off");
   chk_wd_match_reset: assert property (
      (clk_en && wd_en && low_ovf && cph_q[WD_MOD] == cnt_q[15:8]) |=> wd_rst_q)
      else $error("watchdog match gave no reset");
   chk_wd_force_reset: assert property (
      (clk_en && wd_en && wr_hit(wr, cpa_pkg::CPA_WR_CTRL) && wr.data[WD_MOD]) |=> wd_rst_q)
      else $error("forced watchdog reset missing");
   chk_wd_update: assert property (
      (clk_en && wd_en && wr.idx == 3'(WD_MOD) && wr_hit(wr, cpa_pkg::CPA_WR_CMP_HI))
      |=> cph_q[WD_MOD] == $past(wd_upd))
      else $error("watchdog update value wrong");
   chk_lock_holds: assert property (
      lock_q |=> (lock_q && wd_en))
      else $error("locked watchdog was disabled");
   chk_cnt_write_block: assert property (
      (clk_en && wd_en && !tick && wr_hit(wr, cpa_pkg::CPA_WR_CNT_LO)) |=> $stable(cnt_q))
      else $error("counter written under watchdog");
   chk_pwm_off_low: assert property (
      (clk_en && is_pwm(eff[1]) && !eff[1].comp_en) |=> !pin_q[1])
      else $error("pwm with comparator off not low");
   chk_pwm8_reload: assert property (
      (clk_en && is_pwm(eff[1]) && !eff[1].wide && low_ovf
       && !(wr.idx == 3'h1 && wr_hit(wr, cpa_pkg::CPA_WR_CMP_LO)))
      |=> cpl_q[1] == $past(cph_q[1]))
      else $error("pwm8 reload missed");
   chk_rst_pulse: assert property (
      (wd_rst_q && $past(clk_en)) |-> $past(wd_hit || wd_force))
      else $error("watchdog reset without cause");

endmodule : cpa_core
`default_nettype wire

// file: core/cpa_pkg.sv
// Types shared by the counter array compare and watchdog block
package cpa_pkg;

   // Per-module mode register layout
   typedef struct packed {
      logic wide;      // 16-bit pwm select
      logic comp_en;   // Comparator enable
      logic capp;      // Capture on rising edge (unused here)
      logic capn;      // Capture on falling edge (unused here)
      logic match_en;  // Match enable
      logic toggle;    // Toggle enable
      logic pwm;       // Pulse width enable
      logic irq_en;    // Match interrupt enable
   } cpa_mode_t;

   // Write targets of the software write port
   typedef enum logic [2:0] {
      CPA_WR_CTRL,
      CPA_WR_AMODE,
      CPA_WR_CNT_LO,
      CPA_WR_CNT_HI,
      CPA_WR_MMODE,
      CPA_WR_CMP_LO,
      CPA_WR_CMP_HI
   } cpa_wr_sel_t;

   // One software write
   typedef struct packed {
      logic en;
      cpa_wr_sel_t sel;
      logic [2:0] idx;
      logic [7:0] data;
   } cpa_wr_t;

endpackage : cpa_pkg

// file: core/cpa_timebase.sv
// Counter timebase selector producing one tick per counter clock
`timescale 1ns/1ps
`default_nettype none
`include "cpa_consts.svh"

module cpa_timebase (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   // Selection and sources
   input wire logic [2:0] sel,
   input wire logic timer0_ovf,
   input wire logic ext_count_pin,
   input wire logic ext_osc_pin,
   // Tick out
   output logic tick
);

   logic [3:0] pre_q;       // Divide-by-12 prescaler
   logic [2:0] ext_s_q;     // External count input synchroniser
   logic ext_lvl_q;         // Accepted level of the count input
   logic [2:0] osc_s_q;     // External oscillator synchroniser
   logic osc_lvl_q;         // Accepted oscillator level
   logic [2:0] osc_div_q;   // Oscillator divide-by-8
   logic ext_fall;
   logic osc_rise;
   logic tick_q;

   // ************************************************************
   // Prescaler
   // ************************************************************
   // Divide by 4 reuses the divide-by-12 count, since 4 divides 12
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pre_q <= 4'h0;
      end else if (clk_en) begin
         pre_q <= (pre_q == `CPA_PRE_LAST) ? 4'h0 : pre_q + 4'h1;
      end
   end

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   // A level counts only once stages two and three agree
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ext_s_q <= 3'h0;
         osc_s_q <= 3'h0;
         ext_lvl_q <= 1'b0;
         osc_lvl_q <= 1'b0;
      end else if (clk_en) begin
         ext_s_q <= {ext_s_q[1:0], ext_count_pin};
         osc_s_q <= {osc_s_q[1:0], ext_osc_pin};
         if (ext_s_q[1] == ext_s_q[2]) begin
            ext_lvl_q <= ext_s_q[2];
         end
         if (osc_s_q[1] == osc_s_q[2]) begin
            osc_lvl_q <= osc_s_q[2];
         end
      end
   end

   assign ext_fall = ext_lvl_q && (ext_s_q[1] == ext_s_q[2]) && !ext_s_q[2];
   assign osc_rise = !osc_lvl_q && (osc_s_q[1] == osc_s_q[2]) && osc_s_q[2];

   // Oscillator edges counted down by 8
   always_ff @(posedge core_clk) begin
      if (reset) begin
         osc_div_q <= 3'h0;
      end else if (clk_en && osc_rise) begin
         osc_div_q <= osc_div_q + 3'h1;
      end
   end

   // ************************************************************
   // Source select
   // ************************************************************
   // Reserved codes give no tick, so the counter stands still
   always_ff @(posedge core_clk) begin
      if (reset) begin
         tick_q <= 1'b0;
      end else if (clk_en) begin
         unique case (sel)
            `CPA_TB_DIV12: tick_q <= (pre_q == `CPA_PRE_LAST);
            `CPA_TB_DIV4: tick_q <= (pre_q[1:0] == `CPA_DIV4_LAST);
            `CPA_TB_T0OVF: tick_q <= timer0_ovf;
            `CPA_TB_EXTIN: tick_q <= ext_fall;
            `CPA_TB_SYSCLK: tick_q <= 1'b1;
            `CPA_TB_OSC8: tick_q <= osc_rise && (osc_div_q == `CPA_OSC_LAST);
            default: tick_q <= 1'b0;
         endcase
      end
   end

   assign tick = tick_q;

endmodule : cpa_timebase
`default_nettype wire

// file: sim/cpa_pin_watch.sv
// Board-side observer of one module pin: high-time and edge counts
`timescale 1ns/1ps
`default_nettype none
module cpa_pin_watch (
   // Clock and clear
   input wire logic core_clk,
   input wire logic clr,
   // Watched pin
   input wire logic pin,
   // Counts since the last clear
   output logic [15:0] hi_cnt,
   output logic [15:0] edge_cnt
);
   logic last_q; // Pin level one cycle ago
   // Counting per cycle keeps duty and frequency independent of phase
   always_ff @(posedge core_clk) begin
      last_q <= pin;
      if (clr) begin
         hi_cnt <= 16'h0000;
         edge_cnt <= 16'h0000;
      end else begin
         hi_cnt <= hi_cnt + {15'h0000, pin};
         edge_cnt <= edge_cnt + {15'h0000, pin ^ last_q};
      end
   end
endmodule : cpa_pin_watch
`default_nettype wire

// file: sim/test_cpa_core.sv
// Self-checking bench for the compare, pwm and watchdog block
`timescale 1ns/1ps
`default_nettype none
module test_cpa_core;
   logic core_clk;
   logic reset;
   cpa_pkg::cpa_wr_t wr;
   logic [4:0] pin_w;
   logic [4:0] flag_w;
   logic irq_w, run_w, wda_w, wdr_w;
   logic [15:0] cnt_w, hi_w, edg_w;
   logic [2:0] wsel;
   logic wclr;
   int n_errors;
   int n_checks;
   int n;
   // Unused sources held quiet; only the system clock timebases are exercised
   cpa_core cpa_core_inst (.core_clk(core_clk), .reset(reset), .clk_en(1'b1),
      .cpu_idle(1'b0), .timer0_ovf(1'b0), .ext_count_pin(1'b0), .ext_osc_pin(1'b0),
      .wr(wr), .module_io_pin(pin_w), .module_match_flag(flag_w), .match_irq(irq_w),
      .count_value(cnt_w), .counter_run_bit(run_w), .watchdog_active(wda_w),
      .watchdog_reset(wdr_w));
   cpa_pin_watch cpa_pin_watch_inst (.core_clk(core_clk), .clr(wclr), .pin(pin_w[wsel]),
      .hi_cnt(hi_w), .edge_cnt(edg_w));
   // 40 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   task automatic timeout(input string what);
      n_errors++;
      $display("Error %s expected event seen none", what);
      test_done();
   endtask : timeout
   // One write strobe, held for exactly one edge
   task automatic put(input cpa_pkg::cpa_wr_sel_t s, input logic [2:0] i, input logic [7:0] d);
      @(posedge core_clk);
      wr <= '{en: 1'b1, sel: s, idx: i, data: d};
      @(posedge core_clk);
      wr.en <= 1'b0;
   endtask : put
   // Waits up to 600 cycles for pin p to reach level lvl
   task automatic wait_pin(input int p, input logic lvl, input string what);
      n = 0;
      while (pin_w[p] !== lvl && n < 600) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 600) timeout(what);
   endtask : wait_pin
   task automatic do_reset;
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
   endtask : do_reset
   // Settle, then open a measuring window of len cycles on pin p
   task automatic measure(input logic [2:0] p, input int len);
      wsel <= p;
      repeat (300) @(posedge core_clk);
      wclr <= 1'b1;
      @(posedge core_clk);
      wclr <= 1'b0;
      repeat (len) @(posedge core_clk);
      #1;
   endtask : measure
   task automatic test_wd;
      @(posedge core_clk);
      #1;
      check("wd_active", 16'h0001, {15'h0000, wda_w});
      check("pins", 16'h0000, {11'h000, pin_w});
      put(cpa_pkg::CPA_WR_CNT_LO, 3'h0, 8'h55);
      put(cpa_pkg::CPA_WR_CMP_HI, 3'h4, 8'h77);
      n = 0;
      while (wdr_w !== 1'b1 && n < 3300) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 3300) timeout("wd_pulse");
      check("wd_time", 16'h0001, {15'h0000, n > 3050 && n < 3100});
      check("count", 16'h0100, cnt_w);
      check("run_bit", 16'h0000, {15'h0000, run_w});
      $display("test_wd done");
   endtask : test_wd
   task automatic test_timer;
      put(cpa_pkg::CPA_WR_AMODE, 3'h0, 8'h00);
      put(cpa_pkg::CPA_WR_AMODE, 3'h0, 8'h08);
      put(cpa_pkg::CPA_WR_MMODE, 3'h0, 8'h49);
      put(cpa_pkg::CPA_WR_CMP_LO, 3'h0, 8'h20);
      put(cpa_pkg::CPA_WR_CMP_HI, 3'h0, 8'h00);
      put(cpa_pkg::CPA_WR_CTRL, 3'h0, 8'h40);
      n = 0;
      while (flag_w[0] !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 100) timeout("flag0");
      check("count_at_flag", 16'h0020, cnt_w);
      check("wd_active", 16'h0000, {15'h0000, wda_w});
      repeat (300) @(posedge core_clk);
      #1;
      check("flag_held", 16'h0001, {15'h0000, flag_w[0]});
      check("irq", 16'h0001, {15'h0000, irq_w});
      put(cpa_pkg::CPA_WR_CTRL, 3'h0, 8'h40);
      #1;
      check("flag_clear", 16'h0000, {15'h0000, flag_w[0]});
      $display("test_timer done");
   endtask : test_timer
   task automatic test_pwm;
      put(cpa_pkg::CPA_WR_MMODE, 3'h1, 8'h42);
      put(cpa_pkg::CPA_WR_CMP_LO, 3'h1, 8'h40);
      put(cpa_pkg::CPA_WR_CMP_HI, 3'h1, 8'h40);
      measure(3'h1, 256);
      check("pwm8_high", 16'h00c0, hi_w);
      put(cpa_pkg::CPA_WR_MMODE, 3'h1, 8'h02);
      measure(3'h1, 256);
      check("pwm8_off", 16'h0000, hi_w);
      $display("test_pwm done");
   endtask : test_pwm
   task automatic test_freq;
      put(cpa_pkg::CPA_WR_MMODE, 3'h2, 8'h46);
      put(cpa_pkg::CPA_WR_CMP_LO, 3'h2, 8'h00);
      put(cpa_pkg::CPA_WR_CMP_HI, 3'h2, 8'h10);
      measure(3'h2, 512);
      check("freq_edges", 16'h0020, edg_w);
      put(cpa_pkg::CPA_WR_CMP_LO, 3'h2, 8'h00);
      put(cpa_pkg::CPA_WR_CMP_HI, 3'h2, 8'h00);
      measure(3'h2, 512);
      check("freq_256", 16'h0002, edg_w);
      $display("test_freq done");
   endtask : test_freq
   // Wide pwm on module 3 paced by pin waits, flag check and clear, then high-speed toggle
   task automatic test_pwm16;
      put(cpa_pkg::CPA_WR_MMODE, 3'h3, 8'hcb);
      put(cpa_pkg::CPA_WR_CMP_LO, 3'h3, 8'h00);
      put(cpa_pkg::CPA_WR_CMP_HI, 3'h3, 8'hff);
      put(cpa_pkg::CPA_WR_CNT_HI, 3'h0, 8'hfe);
      wait_pin(3, 1'b1, "pwm16_set");
      check("pwm16_set", 16'hff00, cnt_w);
      check("pwm16_flag", 16'h0001, {15'h0000, flag_w[3]});
      put(cpa_pkg::CPA_WR_CTRL, 3'h0, 8'h40);
      wait_pin(3, 1'b0, "pwm16_clr");
      check("pwm16_clr", 16'h0000, cnt_w);
      put(cpa_pkg::CPA_WR_MMODE, 3'h3, 8'h4c);
      put(cpa_pkg::CPA_WR_CNT_HI, 3'h0, 8'hfe);
      wait_pin(3, 1'b1, "hso_toggle");
      check("hso_toggle", 16'hff00, cnt_w);
      $display("test_pwm16 done");
   endtask : test_pwm16
   task automatic test_force;
      put(cpa_pkg::CPA_WR_AMODE, 3'h0, 8'h20);
      @(posedge core_clk);
      #1;
      check("wd_on", 16'h0001, {15'h0000, wda_w});
      put(cpa_pkg::CPA_WR_CTRL, 3'h0, 8'h10);
      #1;
      n = 0;
      while (wdr_w !== 1'b1 && n < 10) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 10) timeout("wd_force");
      check("wd_force", 16'h0001, {15'h0000, wdr_w});
      $display("test_force done");
   endtask : test_force
   // Main sequence
   initial begin
      reset = 1'b1;
      wr = '0;
      wsel = 3'h0;
      wclr = 1'b0;
      n_errors = 0;
      n_checks = 0;
      do_reset();
      test_wd();
      do_reset();
      test_timer();
      test_pwm();
      test_freq();
      test_pwm16();
      test_force();
      test_done();
   end
endmodule : test_cpa_core
`default_nettype wire
